// [hw/debug_port_pkg.sv]
package debug_port_pkg;

  // ----------------------------------------------------------------------
  // Function select codes
  // ----------------------------------------------------------------------
  localparam int unsigned SEL_W = 4;
  typedef logic [SEL_W-1:0] sel_t;

  localparam sel_t SEL_STATE_CHANGE = 4'h0;
  localparam sel_t SEL_STATIC_SLOT  = 4'h1;
  localparam sel_t SEL_MINISLOT     = 4'h2;
  localparam sel_t SEL_RX_FILT_A    = 4'h3;
  localparam sel_t SEL_DYN_SLOT_A   = 4'h4;
  localparam sel_t SEL_FRAME_A      = 4'h5;
  localparam sel_t SEL_VALID_A      = 4'h6;
  localparam sel_t SEL_CYCLE        = 4'h7;
  localparam sel_t SEL_MACROTICK    = 4'h8;
  localparam sel_t SEL_OFFSET_CORR  = 4'h9;
  localparam sel_t SEL_RX_FILT_B    = 4'hA;
  localparam sel_t SEL_DYN_SLOT_B   = 4'hB;
  localparam sel_t SEL_FRAME_B      = 4'hC;
  localparam sel_t SEL_VALID_B      = 4'hD;
  localparam sel_t SEL_RESET        = SEL_STATE_CHANGE;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned STRETCH_CYCLES = 3;
  localparam int unsigned SINGLE_CYCLES  = 1;
  localparam int unsigned VALID_DELAY_BITS = 11;
  localparam int unsigned CNT_W          = 2;
  typedef logic [CNT_W-1:0] cnt_t;
  localparam cnt_t CNT_ZERO    = 2'h0;
  localparam cnt_t CNT_ONE     = 2'h1;
  localparam cnt_t CNT_STRETCH = cnt_t'(STRETCH_CYCLES);
  localparam cnt_t CNT_SINGLE  = cnt_t'(SINGLE_CYCLES);
  localparam int unsigned BITCNT_W = 4;
  typedef logic [BITCNT_W-1:0] bitcnt_t;
  localparam bitcnt_t BITCNT_ZERO  = 4'h0;
  localparam bitcnt_t BITCNT_ONE   = 4'h1;
  localparam bitcnt_t BITCNT_VALID = bitcnt_t'(VALID_DELAY_BITS);

  // ----------------------------------------------------------------------
  // Event carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic dyn_slot;
    logic frame_start;
    logic frame_end_ok;
  } chan_evt_s;

  typedef struct packed {
    logic      state_change;
    logic      static_slot;
    logic      minislot;
    logic      macrotick;
    logic      cycle_start;
    logic      idle_start;
    logic      offset_corr;
    chan_evt_s chan_a;
    chan_evt_s chan_b;
  } proto_evt_s;

  typedef enum logic [2:0] {
    VF_IDLE  = 3'b001,
    VF_COUNT = 3'b010,
    VF_FIRE  = 3'b100
  } vf_state_e;

endpackage

// [hw/pulse_stretch.sv]
`timescale 1ns/1ps
module pulse_stretch
  import debug_port_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_ce,
  input  wire logic i_evt,
  input  wire cnt_t i_len,
  output logic      o_pulse
);

  cnt_t cnt_q;
  cnt_t cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (i_evt) begin
      cnt_d = i_len;
    end else if (cnt_q != CNT_ZERO) begin
      cnt_d = cnt_q - CNT_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= CNT_ZERO;
    end else if (i_ce) begin
      cnt_q <= cnt_d;
    end
  end

  assign o_pulse = (cnt_q != CNT_ZERO);

endmodule

// [hw/valid_frame_delay.sv]
`timescale 1ns/1ps
module valid_frame_delay
  import debug_port_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_ce,
  input  wire logic i_frame_end_ok,
  input  wire logic i_bit_tick,
  output logic      o_fire
);

  vf_state_e state_q;
  vf_state_e state_d;
  bitcnt_t   cnt_q;
  bitcnt_t   cnt_d;

  // Counts bus bit ticks after a good frame end
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      VF_IDLE: begin
        if (i_frame_end_ok) begin
          state_d = VF_COUNT;
          cnt_d   = BITCNT_ZERO;
        end
      end
      VF_COUNT: begin
        if (i_bit_tick) begin
          cnt_d = cnt_q + BITCNT_ONE;
          if (cnt_q + BITCNT_ONE == BITCNT_VALID) begin
            state_d = VF_FIRE;
          end
        end
      end
      VF_FIRE: begin
        state_d = i_frame_end_ok ? VF_COUNT : VF_IDLE;
        cnt_d   = BITCNT_ZERO;
      end
      default: begin
        state_d = VF_IDLE;
        cnt_d   = BITCNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= VF_IDLE;
      cnt_q   <= BITCNT_ZERO;
    end else if (i_ce) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign o_fire = (state_q == VF_FIRE);

endmodule

// [hw/protocol_event_debug_port.sv]
`timescale 1ns/1ps
module protocol_event_debug_port
  import debug_port_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_ce,
  input  wire proto_evt_s i_evt,
  input  wire logic       i_bit_tick,
  input  wire logic       i_filtered_receive_chan_a,
  input  wire logic       i_filtered_receive_chan_b,
  input  wire sel_t       i_debug_output_select_one,
  input  wire sel_t       i_debug_output_select_two,
  input  wire logic       i_guardian_attached,
  input  wire logic       i_guardian_out_one,
  input  wire logic       i_guardian_out_two,
  output logic            o_debug_pin_one,
  output logic            o_debug_pin_two
);

  // ----------------------------------------------------------------------
  // Event edge detection
  // ----------------------------------------------------------------------
  logic rx_a_q;
  logic rx_b_q;
  logic rx_a_d;
  logic rx_b_d;
  logic rx_a_rise;
  logic rx_b_rise;

  always_comb begin
    rx_a_d = i_filtered_receive_chan_a;
    rx_b_d = i_filtered_receive_chan_b;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      // Receive line idles high: no false edge after reset
      rx_a_q <= 1'b1;
      rx_b_q <= 1'b1;
    end else if (i_ce) begin
      rx_a_q <= rx_a_d;
      rx_b_q <= rx_b_d;
    end
  end

  assign rx_a_rise = rx_a_d & ~rx_a_q;
  assign rx_b_rise = rx_b_d & ~rx_b_q;

  // ----------------------------------------------------------------------
  // Valid frame delay, one per channel
  // ----------------------------------------------------------------------
  logic valid_a_fire;
  logic valid_b_fire;

  valid_frame_delay u_vf_a (
    .i_clk          (i_clk),
    .i_sys_rst      (i_sys_rst),
    .i_ce           (i_ce),
    .i_frame_end_ok (i_evt.chan_a.frame_end_ok),
    .i_bit_tick     (i_bit_tick),
    .o_fire         (valid_a_fire)
  );

  valid_frame_delay u_vf_b (
    .i_clk          (i_clk),
    .i_sys_rst      (i_sys_rst),
    .i_ce           (i_ce),
    .i_frame_end_ok (i_evt.chan_b.frame_end_ok),
    .i_bit_tick     (i_bit_tick),
    .o_fire         (valid_b_fire)
  );

  // ----------------------------------------------------------------------
  // Pulse stretchers
  // ----------------------------------------------------------------------
  localparam int unsigned N_PULSE = 12;
  localparam int unsigned P_STATE = 0;
  localparam int unsigned P_STATIC = 1;
  localparam int unsigned P_MINI = 2;
  localparam int unsigned P_RXA = 3;
  localparam int unsigned P_DYNA = 4;
  localparam int unsigned P_FRMA = 5;
  localparam int unsigned P_VALA = 6;
  localparam int unsigned P_MTICK = 7;
  localparam int unsigned P_RXB = 8;
  localparam int unsigned P_DYNB = 9;
  localparam int unsigned P_FRMB = 10;
  localparam int unsigned P_VALB = 11;

  logic [N_PULSE-1:0] trig;
  logic [N_PULSE-1:0] pulse;

  always_comb begin
    trig           = '0;
    trig[P_STATE]  = i_evt.state_change;
    trig[P_STATIC] = i_evt.static_slot;
    trig[P_MINI]   = i_evt.minislot;
    trig[P_RXA]    = rx_a_rise;
    trig[P_DYNA]   = i_evt.chan_a.dyn_slot;
    trig[P_FRMA]   = i_evt.chan_a.frame_start;
    trig[P_VALA]   = valid_a_fire;
    trig[P_MTICK]  = i_evt.macrotick;
    trig[P_RXB]    = rx_b_rise;
    trig[P_DYNB]   = i_evt.chan_b.dyn_slot;
    trig[P_FRMB]   = i_evt.chan_b.frame_start;
    trig[P_VALB]   = valid_b_fire;
  end

  // Shared protocol events
  pulse_stretch u_ps_state (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_STATE]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_STATE])
  );

  pulse_stretch u_ps_static (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_STATIC]),
    .i_len     (CNT_SINGLE),
    .o_pulse   (pulse[P_STATIC])
  );

  pulse_stretch u_ps_mini (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_MINI]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_MINI])
  );

  pulse_stretch u_ps_mtick (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_MTICK]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_MTICK])
  );

  // Channel A events
  pulse_stretch u_ps_rx_a (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_RXA]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_RXA])
  );

  pulse_stretch u_ps_dyn_a (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_DYNA]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_DYNA])
  );

  pulse_stretch u_ps_frame_a (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_FRMA]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_FRMA])
  );

  pulse_stretch u_ps_valid_a (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_VALA]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_VALA])
  );

  // Channel B events
  pulse_stretch u_ps_rx_b (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_RXB]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_RXB])
  );

  pulse_stretch u_ps_dyn_b (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_DYNB]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_DYNB])
  );

  pulse_stretch u_ps_frame_b (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_FRMB]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_FRMB])
  );

  pulse_stretch u_ps_valid_b (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_evt     (trig[P_VALB]),
    .i_len     (CNT_STRETCH),
    .o_pulse   (pulse[P_VALB])
  );

  // ----------------------------------------------------------------------
  // Cycle level and offset correction strobe
  // ----------------------------------------------------------------------
  logic cycle_q;
  logic cycle_d;
  logic soc_q;
  logic soc_d;

  always_comb begin
    cycle_d = cycle_q;
    if (i_evt.cycle_start) begin
      cycle_d = 1'b1;
    end else if (i_evt.idle_start) begin
      cycle_d = 1'b0;
    end
    soc_d = i_evt.offset_corr & ~cycle_d;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cycle_q <= 1'b0;
      soc_q   <= 1'b0;
    end else if (i_ce) begin
      cycle_q <= cycle_d;
      soc_q   <= soc_d;
    end
  end

  // ----------------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------------
  function automatic logic pick(input sel_t sel,
                                input logic [N_PULSE-1:0] p,
                                input logic cyc,
                                input logic soc);
    logic r;
    r = 1'b0;
    case (sel)
      SEL_STATE_CHANGE: r = p[P_STATE];
      SEL_STATIC_SLOT:  r = p[P_STATIC];
      SEL_MINISLOT:     r = p[P_MINI];
      SEL_RX_FILT_A:    r = p[P_RXA];
      SEL_DYN_SLOT_A:   r = p[P_DYNA];
      SEL_FRAME_A:      r = p[P_FRMA];
      SEL_VALID_A:      r = p[P_VALA];
      SEL_CYCLE:        r = cyc;
      SEL_MACROTICK:    r = p[P_MTICK];
      SEL_OFFSET_CORR:  r = soc;
      SEL_RX_FILT_B:    r = p[P_RXB];
      SEL_DYN_SLOT_B:   r = p[P_DYNB];
      SEL_FRAME_B:      r = p[P_FRMB];
      SEL_VALID_B:      r = p[P_VALB];
      default:          r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Debug pin one
  // ----------------------------------------------------------------------
  logic pin_one_q;
  logic pin_one_d;

  always_comb begin
    pin_one_d = pick(i_debug_output_select_one, pulse, cycle_q, soc_q);
    // Guardian outputs own the pin when attached
    if (i_guardian_attached) begin
      pin_one_d = i_guardian_out_one;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_one_q <= 1'b0;
    end else if (i_ce) begin
      pin_one_q <= pin_one_d;
    end
  end

  assign o_debug_pin_one = pin_one_q;

  // ----------------------------------------------------------------------
  // Debug pin two
  // ----------------------------------------------------------------------
  logic pin_two_q;
  logic pin_two_d;

  always_comb begin
    pin_two_d = pick(i_debug_output_select_two, pulse, cycle_q, soc_q);
    // Guardian outputs own the pin when attached
    if (i_guardian_attached) begin
      pin_two_d = i_guardian_out_two;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_two_q <= 1'b0;
    end else if (i_ce) begin
      pin_two_q <= pin_two_d;
    end
  end

  assign o_debug_pin_two = pin_two_q;

endmodule

// [testbench/debug_port_chk.sv]
`timescale 1ns/1ps
module debug_port_chk
  import debug_port_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_ce,
  input wire proto_evt_s i_evt,
  input wire logic       i_bit_tick,
  input wire logic       i_filtered_receive_chan_a,
  input wire logic       i_filtered_receive_chan_b,
  input wire sel_t       i_debug_output_select_one,
  input wire sel_t       i_debug_output_select_two,
  input wire logic       i_guardian_attached,
  input wire logic       i_guardian_out_one,
  input wire logic       i_guardian_out_two,
  input wire logic       o_debug_pin_one,
  input wire logic       o_debug_pin_two
);
  sel_t    s1, s2;
  logic    g, p1, p2;
  bitcnt_t tk_q, tk_d;
  assign s1 = i_debug_output_select_one;
  assign s2 = i_debug_output_select_two;
  assign g  = i_guardian_attached;
  assign p1 = o_debug_pin_one;
  assign p2 = o_debug_pin_two;

  // ----
  // Bit ticks since last frame end
  // ----
  always_comb begin
    tk_d = tk_q;
    if (i_evt.chan_a.frame_end_ok || i_evt.chan_b.frame_end_ok) begin
      tk_d = BITCNT_ZERO;
    end else if (i_bit_tick && tk_q != 4'hF) begin
      tk_d = tk_q + BITCNT_ONE;
    end
  end
  always_ff @(posedge i_clk) begin
    tk_q <= i_sys_rst ? BITCNT_ZERO : tk_d;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst || !i_ce);

  mini_width_a: assert property (s1 == SEL_MINISLOT && !g && i_evt.minislot
    |-> ##2 p1 [*3]) else $error("minislot pulse wrong");
  strobe_cause_a: assert property ($rose(p1) && s1 == SEL_MINISLOT && !g
    |-> $past(i_evt.minislot, 2)) else $error("pin rose without event");
  static_single_a: assert property (s1 == SEL_STATIC_SLOT && !g && i_evt.static_slot
    ##1 !i_evt.static_slot |-> ##1 p1 ##1 !p1) else $error("static pulse wrong");
  cycle_rise_a: assert property (s1 == SEL_CYCLE && !g && i_evt.cycle_start
    |-> ##2 p1) else $error("cycle level not raised");
  cycle_hold_a: assert property (s1 == SEL_CYCLE && !g && p1 && !i_evt.idle_start
    && !$past(i_evt.idle_start) |=> p1) else $error("cycle level dropped");
  idle_drop_a: assert property (s1 == SEL_CYCLE && !g && i_evt.idle_start
    |-> ##2 !p1) else $error("cycle level not dropped");
  valid_delay_a: assert property (($rose(p1) && s1 == SEL_VALID_A && !g)
    || ($rose(p2) && s2 == SEL_VALID_B && !g) |-> tk_q == BITCNT_VALID)
    else $error("valid frame strobe at wrong bit");
  rx_edge_a: assert property (s1 == SEL_RX_FILT_A && !g
    && $rose(i_filtered_receive_chan_a) |-> ##2 p1 [*3]) else $error("rx pulse wrong");
  pin_two_a: assert property (s2 == SEL_MACROTICK && !g && i_evt.macrotick
    |-> ##2 p2 [*3]) else $error("macrotick pulse wrong");
  guardian_route_a: assert property ((g && $stable(i_guardian_out_one)) [*3]
    |-> p1 == i_guardian_out_one) else $error("guardian not routed");
endmodule

// [testbench/debug_observer.sv]
`timescale 1ns/1ps
module debug_observer (
  input  wire logic i_clk,
  input  wire logic i_pin,
  output logic [7:0] o_rises,
  output logic [7:0] o_width
);
  logic       last_q  = 1'b0;
  logic [7:0] run_q   = 8'h00;
  logic [7:0] rises_q = 8'h00;
  logic [7:0] width_q = 8'h00;
  assign o_rises = rises_q;
  assign o_width = width_q;
  // Width of last high run, count of rises
  always @(posedge i_clk) begin
    last_q <= i_pin;
    if (i_pin === 1'b1) begin
      run_q <= run_q + 8'h01;
    end else if (last_q) begin
      width_q <= run_q;
      run_q   <= 8'h00;
    end
    if (i_pin === 1'b1 && !last_q) begin
      rises_q <= rises_q + 8'h01;
    end
  end
endmodule

// [testbench/protocol_event_debug_port_tb.sv]
`timescale 1ns/1ps
module protocol_event_debug_port_tb;
  import debug_port_pkg::*;
  logic       i_clk;
  logic       i_sys_rst;
  logic       i_ce;
  proto_evt_s i_evt;
  logic       i_bit_tick;
  logic       i_filtered_receive_chan_a;
  logic       i_filtered_receive_chan_b;
  sel_t       i_debug_output_select_one;
  sel_t       i_debug_output_select_two;
  logic       i_guardian_attached;
  logic       i_guardian_out_one;
  logic       i_guardian_out_two;
  logic       o_debug_pin_one;
  logic       o_debug_pin_two;
  logic [7:0] r1, w1, r2, w2;
  int         fail_count = 0;
  int         n_compared = 0;

  protocol_event_debug_port dut_u (.i_clk, .i_sys_rst, .i_ce, .i_evt, .i_bit_tick,
    .i_filtered_receive_chan_a, .i_filtered_receive_chan_b, .i_debug_output_select_one,
    .i_debug_output_select_two, .i_guardian_attached, .i_guardian_out_one,
    .i_guardian_out_two, .o_debug_pin_one, .o_debug_pin_two);
  debug_observer obs1_u (.i_clk, .i_pin(o_debug_pin_one), .o_rises(r1), .o_width(w1));
  debug_observer obs2_u (.i_clk, .i_pin(o_debug_pin_two), .o_rises(r2), .o_width(w2));

  always #5 i_clk = ~i_clk;

  // ----
  // Helpers
  // ----
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic sel(input sel_t a, input sel_t b);
    i_debug_output_select_one = a;
    i_debug_output_select_two = b;
    cyc(2);
  endtask
  // One-cycle event for a function code; unused codes give idle start
  task automatic pulse(input sel_t c);
    case (c)
      SEL_STATE_CHANGE: i_evt.state_change = 1'b1;
      SEL_STATIC_SLOT:  i_evt.static_slot = 1'b1;
      SEL_MINISLOT:     i_evt.minislot = 1'b1;
      SEL_RX_FILT_A:    i_filtered_receive_chan_a = 1'b1;
      SEL_DYN_SLOT_A:   i_evt.chan_a.dyn_slot = 1'b1;
      SEL_FRAME_A:      i_evt.chan_a.frame_start = 1'b1;
      SEL_VALID_A:      i_evt.chan_a.frame_end_ok = 1'b1;
      SEL_CYCLE:        i_evt.cycle_start = 1'b1;
      SEL_MACROTICK:    i_evt.macrotick = 1'b1;
      SEL_OFFSET_CORR:  i_evt.offset_corr = 1'b1;
      SEL_RX_FILT_B:    i_filtered_receive_chan_b = 1'b1;
      SEL_DYN_SLOT_B:   i_evt.chan_b.dyn_slot = 1'b1;
      SEL_FRAME_B:      i_evt.chan_b.frame_start = 1'b1;
      SEL_VALID_B:      i_evt.chan_b.frame_end_ok = 1'b1;
      default:          i_evt.idle_start = 1'b1;
    endcase
    cyc(1);
    i_evt = '0;
    i_filtered_receive_chan_a = 1'b0;
    i_filtered_receive_chan_b = 1'b0;
    cyc(8);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_strobes();
    sel_t        c [9] = '{SEL_STATE_CHANGE, SEL_MINISLOT, SEL_RX_FILT_A, SEL_DYN_SLOT_A,
                           SEL_FRAME_A, SEL_MACROTICK, SEL_RX_FILT_B, SEL_DYN_SLOT_B, SEL_FRAME_B};
    logic [7:0]  a, b;
    logic [31:0] e;
    foreach (c[i]) begin
      sel(c[i], c[i]);
      a = r1;
      b = r2;
      pulse(c[i]);
      e = {a + 8'h01, 8'h03, b + 8'h01, 8'h03};
      chk({r1, w1, r2, w2}, e);
    end
    $display("strobes done");
  endtask
  task automatic t_static();
    logic [7:0] a, b;
    sel(SEL_STATIC_SLOT, SEL_MINISLOT);
    a = r1;
    b = r2;
    pulse(SEL_STATIC_SLOT);
    chk({r1 - a, w1, r2 - b}, 24'h01_0100);
    $display("static slot done");
  endtask
  task automatic t_cycle();
    logic [7:0] b;
    sel(SEL_CYCLE, SEL_OFFSET_CORR);
    b = r2;
    pulse(SEL_CYCLE);
    pulse(SEL_OFFSET_CORR);
    chk({o_debug_pin_one, r2 - b}, 9'h100);
    pulse(4'hE);
    pulse(SEL_OFFSET_CORR);
    chk({o_debug_pin_one, r2 - b, w2}, 17'h0_0101);
    $display("cycle and offset done");
  endtask
  task automatic t_valid();
    logic [7:0] a;
    for (int ch = 0; ch < 2; ch++) begin
      sel(SEL_VALID_A, SEL_VALID_B);
      a = ch ? r2 : r1;
      pulse(ch ? SEL_VALID_B : SEL_VALID_A);
      for (int k = 1; k <= 11; k++) begin
        if (k == 11) chk((ch ? r2 : r1) - a, 32'h0000_0000);
        i_bit_tick = 1'b1;
        cyc(1);
        i_bit_tick = 1'b0;
        cyc(3);
      end
      cyc(6);
      chk({(ch ? r2 : r1) - a, ch ? w2 : w1}, 16'h0103);
    end
    $display("valid frame done");
  endtask
  task automatic t_guard();
    i_guardian_attached = 1'b1;
    i_guardian_out_one = 1'b1;
    cyc(4);
    chk({o_debug_pin_one, o_debug_pin_two}, 2'b10);
    i_guardian_out_one = 1'b0;
    i_guardian_out_two = 1'b1;
    cyc(4);
    chk({o_debug_pin_one, o_debug_pin_two}, 2'b01);
    i_guardian_out_two = 1'b0;
    cyc(4);
    i_guardian_attached = 1'b0;
    cyc(4);
    $display("guardian done");
  endtask
  task automatic t_freeze();
    logic [7:0] a, b;
    sel(4'hE, 4'hF);
    a = r1;
    b = r2;
    pulse(SEL_MINISLOT);
    pulse(SEL_CYCLE);
    pulse(4'hE);
    chk({r1 - a, r2 - b}, 16'h0000);
    sel(SEL_MINISLOT, SEL_MINISLOT);
    a = r1;
    i_evt.minislot = 1'b1;
    cyc(1);
    i_evt = '0;
    cyc(2);
    i_ce = 1'b0;
    cyc(4);
    i_ce = 1'b1;
    cyc(8);
    chk({r1 - a, w1}, 16'h0107);
    $display("unused codes and freeze done");
  endtask

  initial begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    i_evt = '0;
    i_bit_tick = 1'b0;
    i_filtered_receive_chan_a = 1'b0;
    i_filtered_receive_chan_b = 1'b0;
    i_debug_output_select_one = SEL_RESET;
    i_debug_output_select_two = SEL_RESET;
    i_guardian_attached = 1'b0;
    i_guardian_out_one = 1'b0;
    i_guardian_out_two = 1'b0;
    cyc(10);
    i_sys_rst = 1'b0;
    cyc(2);
    t_strobes();
    t_static();
    t_cycle();
    t_valid();
    t_guard();
    t_freeze();
    stop_test();
  end
  initial begin
    #50000;
    fail_count++;
    stop_test();
  end
endmodule

bind protocol_event_debug_port debug_port_chk chk_u (.i_clk, .i_sys_rst, .i_ce, .i_evt,
  .i_bit_tick, .i_filtered_receive_chan_a, .i_filtered_receive_chan_b,
  .i_debug_output_select_one, .i_debug_output_select_two, .i_guardian_attached,
  .i_guardian_out_one, .i_guardian_out_two, .o_debug_pin_one, .o_debug_pin_two);
